/* src/bpc_pkg.sv */
// Package with the register map, field layout and reset values of the port block
package bpc_pkg;

    // ==================================================================
    // Widths
    localparam int PORT_W = 8;                        // Pins in the port
    localparam int DATA_W = 32;                       // Bus data width
    localparam int STRB_W = DATA_W / 8;               // Byte enables
    localparam int SYNC_STAGES = 3;                   // Pin sampling depth

    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_DATA   = 8'h00;        // port_c_data
    localparam logic [7:0] OFS_DIR    = 8'h04;        // port_c_direction
    localparam logic [7:0] OFS_ALT    = 8'h08;        // alt_pin_function_select
    localparam logic [7:0] OFS_ANALOG = 8'h0c;        // Analog duty per pin
    localparam logic [7:0] OFS_SET    = 8'h10;        // Bit-set on the data latch
    localparam logic [7:0] OFS_CLR    = 8'h14;        // Bit-clear on the data latch

    // ==================================================================
    // Fields of alt_pin_function_select
    localparam int ALT_CC2_BIT = 0;                   // compare2_location_select
    localparam int ALT_SS_BIT  = 1;                   // slave_select_location_select
    localparam logic [7:0] ALT_MASK = 8'h03;          // Implemented bits

    // ==================================================================
    // Reset values
    localparam logic [7:0] RST_DIR    = 8'hff;        // All pins inputs
    localparam logic [7:0] RST_ALT    = 8'h00;
    localparam logic [7:0] RST_ANALOG = 8'h00;        // All pins digital
    localparam logic [7:0] RST_LATCH  = 8'h00;        // Stands for an unknown latch

    // ==================================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* src/bpc_pin_if.sv */
// Interface between the pin sampler and the port register logic
`timescale 1ns/1ps
`default_nettype none

interface bpc_pin_if #(
    parameter int W = 8
);
    logic [W-1:0] raw;                                // Pin levels as they arrive
    logic [W-1:0] level;                              // Settled pin levels

    modport sampler (input raw, output level);
    modport port    (output raw, input level);
endinterface

`default_nettype wire

/* src/bpc_pin_sync.sv */
// Three-stage pin sampler with agreement filter on the last two stages
`timescale 1ns/1ps
`default_nettype none

module bpc_pin_sync #(
    parameter int W = 8
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  ce,
    bpc_pin_if.sampler pins
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;
    logic [W-1:0] agree;

    // ==================================================================
    // Filter: a bit moves only when stages two and three agree
    assign agree     = ~(s2_r ^ s3_r);
    assign level_nxt = (s2_r & agree) | (level_r & ~agree);
    assign pins.level = level_r;

    // Sampling chain, first stage read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            level_r <= '0;
        end else if (ce) begin
            s1_r    <= pins.raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

endmodule

`default_nettype wire

/* src/bpc_port_c.sv */
// Eight-pin bidirectional port with direction, data latch and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module bpc_port_c #(
    parameter int ADDR_W = 8,
    parameter int PINS   = bpc_pkg::PORT_W
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [bpc_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [bpc_pkg::STRB_W-1:0]  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ADDR_W-1:0]           s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [bpc_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [PINS-1:0]             pin_in,
    output logic [PINS-1:0]                  pin_out,
    output logic [PINS-1:0]                  pin_oe,
    output logic                             compare2_location_select,
    output logic                             slave_select_location_select
);

    // ==================================================================
    // Register state
    logic [PINS-1:0]                  latch_r;             // Output latch
    logic [PINS-1:0]                  latch_nxt;
    logic [PINS-1:0]                  dir_r;               // direction_bits
    logic [PINS-1:0]                  dir_nxt;
    logic [PINS-1:0]                  oe_r;
    logic [PINS-1:0]                  analog_r;
    logic [PINS-1:0]                  analog_nxt;
    logic [bpc_pkg::PORT_W-1:0]       alt_r;
    logic [bpc_pkg::PORT_W-1:0]       alt_nxt;

    // Write channel holding state
    logic                             aw_held_r;
    logic                             aw_held_nxt;
    logic                             w_held_r;
    logic                             w_held_nxt;
    logic [7:0]                       wr_addr_r;
    logic [bpc_pkg::DATA_W-1:0]       wr_data_r;
    logic [bpc_pkg::STRB_W-1:0]       wr_strb_r;
    logic                             awready_r;
    logic                             wready_r;
    logic                             bvalid_r;
    logic [1:0]                       bresp_r;

    // Read channel state
    logic                             arready_r;
    logic                             rvalid_r;
    logic [bpc_pkg::DATA_W-1:0]       rdata_r;
    logic [1:0]                       rresp_r;

    // ==================================================================
    // Pin sampler
    bpc_pin_if #(.W(PINS)) pins_if ();
    logic [PINS-1:0]                  pin_level_bits;
    logic [PINS-1:0]                  port_rd_value;

    assign pins_if.raw    = pin_in;
    assign pin_level_bits = pins_if.level;

    bpc_pin_sync #(
        .W     (PINS)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pins  (pins_if.sampler)
    );

    // Settled pin levels with analog pins forced low
    assign port_rd_value = pin_level_bits & ~analog_r;

    // ==================================================================
    // Write path decode
    logic                             aw_take;
    logic                             w_take;
    logic                             wr_go;
    logic                             wr_lane0;
    logic                             hit_data_w;
    logic                             hit_dir_w;
    logic                             hit_alt_w;
    logic                             hit_ana_w;
    logic                             hit_set_w;
    logic                             hit_clr_w;
    logic                             hit_any_w;
    logic [7:0]                       wr_addr_in;
    logic [PINS-1:0]                  wr_bits;

    assign aw_take    = s_axi_awvalid & awready_r;
    assign w_take     = s_axi_wvalid & wready_r;
    assign wr_go      = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_lane0   = wr_strb_r[0];
    assign wr_bits    = wr_data_r[PINS-1:0];
    assign wr_addr_in = 8'(s_axi_awaddr);
    assign hit_data_w = (wr_addr_r == bpc_pkg::OFS_DATA);
    assign hit_dir_w  = (wr_addr_r == bpc_pkg::OFS_DIR);
    assign hit_alt_w  = (wr_addr_r == bpc_pkg::OFS_ALT);
    assign hit_ana_w  = (wr_addr_r == bpc_pkg::OFS_ANALOG);
    assign hit_set_w  = (wr_addr_r == bpc_pkg::OFS_SET);
    assign hit_clr_w  = (wr_addr_r == bpc_pkg::OFS_CLR);
    assign hit_any_w  = hit_data_w | hit_dir_w | hit_alt_w | hit_ana_w | hit_set_w | hit_clr_w;

    // Channel holding: each address and data taken once, freed on the write
    assign aw_held_nxt = (aw_held_r & ~wr_go) | aw_take;
    assign w_held_nxt  = (w_held_r & ~wr_go) | w_take;

    // ==================================================================
    // Register next values
    // Latch is rebuilt from the pins on set, clear and data writes without lane 0, so undriven bits take pin levels
    assign latch_nxt =
        !wr_go                   ? latch_r :
        (hit_data_w && wr_lane0) ? wr_bits :
        hit_data_w               ? port_rd_value :
        hit_set_w                ? (port_rd_value | wr_bits) :
        hit_clr_w                ? (port_rd_value & ~wr_bits) :
                                   latch_r;
    assign dir_nxt    = (wr_go && hit_dir_w && wr_lane0) ? wr_bits : dir_r;
    assign analog_nxt = (wr_go && hit_ana_w && wr_lane0) ? wr_bits : analog_r;
    assign alt_nxt    = (wr_go && hit_alt_w && wr_lane0)
                      ? (wr_data_r[bpc_pkg::PORT_W-1:0] & bpc_pkg::ALT_MASK)
                      : alt_r;

    // Port registers; drivers follow direction alone, analog duty or not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r  <= bpc_pkg::RST_LATCH;
            dir_r    <= bpc_pkg::RST_DIR;
            oe_r     <= ~bpc_pkg::RST_DIR;
            analog_r <= bpc_pkg::RST_ANALOG;
            alt_r    <= bpc_pkg::RST_ALT;
        end else if (ce) begin
            latch_r  <= latch_nxt;
            dir_r    <= dir_nxt;
            oe_r     <= ~dir_nxt;
            analog_r <= analog_nxt;
            alt_r    <= alt_nxt;
        end
    end

    // Write channel handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
            wr_strb_r <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= bpc_pkg::RESP_OKAY;
        end else if (ce) begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= ~aw_held_nxt;
            wready_r  <= ~w_held_nxt;
            if (aw_take) begin
                wr_addr_r <= wr_addr_in;
            end
            if (w_take) begin
                wr_data_r <= s_axi_wdata;
                wr_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= hit_any_w ? bpc_pkg::RESP_OKAY : bpc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Read path decode
    logic                             ar_take;
    logic [7:0]                       rd_addr_in;
    logic [PINS-1:0]                  rd_bits;
    logic                             rd_hit;
    logic                             rd_is_data_r;

    assign ar_take    = s_axi_arvalid & arready_r;
    assign rd_addr_in = 8'(s_axi_araddr);
    assign rd_hit     = (rd_addr_in == bpc_pkg::OFS_DATA) | (rd_addr_in == bpc_pkg::OFS_DIR)
                      | (rd_addr_in == bpc_pkg::OFS_ALT) | (rd_addr_in == bpc_pkg::OFS_ANALOG)
                      | (rd_addr_in == bpc_pkg::OFS_SET) | (rd_addr_in == bpc_pkg::OFS_CLR);
    // Set and clear offsets read back the latch
    assign rd_bits =
        (rd_addr_in == bpc_pkg::OFS_DATA)   ? port_rd_value :
        (rd_addr_in == bpc_pkg::OFS_DIR)    ? dir_r :
        (rd_addr_in == bpc_pkg::OFS_ALT)    ? alt_r[PINS-1:0] :
        (rd_addr_in == bpc_pkg::OFS_ANALOG) ? analog_r :
        rd_hit                              ? latch_r :
                                              '0;

    // Read channel: one answer per address, held until taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_r    <= 1'b0;
            rvalid_r     <= 1'b0;
            rdata_r      <= '0;
            rresp_r      <= bpc_pkg::RESP_OKAY;
            rd_is_data_r <= 1'b0;
        end else if (ce) begin
            if (ar_take) begin
                arready_r    <= 1'b0;
                rvalid_r     <= 1'b1;
                rdata_r      <= {{(bpc_pkg::DATA_W-PINS){1'b0}}, rd_bits};
                rresp_r      <= rd_hit ? bpc_pkg::RESP_OKAY : bpc_pkg::RESP_SLVERR;
                rd_is_data_r <= (rd_addr_in == bpc_pkg::OFS_DATA);
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end else if (!rvalid_r) begin
                arready_r <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Outputs
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign pin_out       = latch_r;
    assign pin_oe        = oe_r;
    assign compare2_location_select     = alt_r[bpc_pkg::ALT_CC2_BIT];
    assign slave_select_location_select = alt_r[bpc_pkg::ALT_SS_BIT];

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic wr_data_full;
    logic wr_data_part;
    assign wr_data_full = ce & wr_go & hit_data_w & wr_lane0;
    assign wr_data_part = ce & wr_go & hit_data_w & ~wr_lane0;

    oe_follows_dir_a: assert property (pin_oe == ~dir_r)
        else $error("pin drive enable disagrees with direction");

    latch_to_pin_a: assert property (
        wr_data_full |=> (pin_out == $past(wr_bits)) && (pin_oe == $past(oe_r)))
        else $error("written latch value not on pins next cycle");

    rmw_latch_a: assert property (
        wr_data_part |=> latch_r == $past(port_rd_value))
        else $error("partial data write did not store pin levels");

    dir_write_a: assert property (
        (ce && wr_go && hit_dir_w && wr_lane0) |=> dir_r == $past(wr_bits))
        else $error("direction write not stored");

    read_pins_a: assert property (
        (ar_take && ce && rd_addr_in == bpc_pkg::OFS_DATA) |=> rdata_r == $past(port_rd_value))
        else $error("data read does not return pin levels");

    analog_zero_a: assert property (
        (ar_take && ce && rd_addr_in == bpc_pkg::OFS_DATA)
        |=> (rdata_r[PINS-1:0] & $past(analog_r)) == '0)
        else $error("analog pin read as one");

    upper_zero_a: assert property (
        s_axi_rvalid |-> (rdata_r[bpc_pkg::DATA_W-1:PINS] == '0)
        && ((alt_r & ~bpc_pkg::ALT_MASK) == '0))
        else $error("unimplemented bits read nonzero");

    pin_settle_a: assert property (
        (ce && $stable(pin_in))[*5] |=> pin_level_bits == $past(pin_in))
        else $error("steady pin not reflected after sampling");

    alt_select_a: assert property (
        (ce && wr_go && hit_alt_w && wr_lane0) |=>
        compare2_location_select == $past(wr_data_r[bpc_pkg::ALT_CC2_BIT]))
        else $error("compare2 location select not updated");

    write_resp_a: assert property (
        (ce && wr_go) |=> s_axi_bvalid)
        else $error("write response missing");

    bresp_hold_a: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    rdata_hold_a: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    rmw_set_a: assert property (
        (ce && wr_go && hit_set_w) |=> latch_r == ($past(port_rd_value) | $past(wr_bits)))
        else $error("bit-set write did not build on pin levels");

    rmw_clear_a: assert property (
        (ce && wr_go && hit_clr_w) |=> latch_r == ($past(port_rd_value) & ~$past(wr_bits)))
        else $error("bit-clear write did not build on pin levels");

    ce_freeze_a: assert property (
        !ce |=> $stable(latch_r) && $stable(dir_r) && $stable(pin_level_bits))
        else $error("state moved while clock enable low");

    unmapped_read_a: assert property (
        (ce && ar_take && !rd_hit)
        |=> (s_axi_rresp == bpc_pkg::RESP_SLVERR) && (s_axi_rdata == '0))
        else $error("unmapped read not refused");

    data_write_c: cover property (wr_data_full ##1 pin_oe != '0);
    rmw_set_c:    cover property (ce && wr_go && hit_set_w);
    data_read_c:  cover property (s_axi_rvalid && s_axi_rready && rd_is_data_r);
    unmapped_c:   cover property (s_axi_rvalid && s_axi_rresp == bpc_pkg::RESP_SLVERR);

endmodule

`default_nettype wire

/* tb/bpc_board.sv */
// Board model: pull-ups and optional external drivers on the eight port pins
`timescale 1ns/1ps
`default_nettype none

module bpc_board (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_in
);
    // ==========================================================
    // Pin resolution
    // Driven pin shows the latch, else external source, else pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

`default_nettype wire

/* tb/bidirectional_port_c_test.sv */
// Self-checking bench for the port block over its register bus
`timescale 1ns/1ps
`default_nettype none

module bidirectional_port_c_test;
    logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, cc2_sel, ss_sel, ce;
    logic [7:0]  awaddr, araddr, pin_in, pin_out, pin_oe, ext_val, ext_en;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          mismatches, comparisons;

    bpc_port_c uut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .compare2_location_select(cc2_sel),
        .slave_select_location_select(ss_sel));
    bpc_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    // ==========================================================
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Reporting
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int   n;
        logic ah, wh, bh;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            ah = awvalid && (awready === 1'b1);
            wh = wvalid && (wready === 1'b1);
            bh = (bvalid === 1'b1);
            r = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end while (!bh && n < 50);
        bready <= 1'b0;
        if (!bh) begin
            mismatches++;
            end_sim();
        end
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int   n;
        logic arh, rh;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            arh = arvalid && (arready === 1'b1);
            rh = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (arh) arvalid <= 1'b0;
            n++;
        end while (!rh && n < 50);
        rready <= 1'b0;
        if (!rh) begin
            mismatches++;
            end_sim();
        end
        chk(d, ed, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask

    task automatic pins(input logic [7:0] eo, input logic [7:0] ee);
        @(negedge clk);
        chk({24'h0, pin_out}, {24'h0, eo}, "pin_out");
        chk({24'h0, pin_oe}, {24'h0, ee}, "pin_oe");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        ext_val = 8'h00;
        ext_en = 8'h00;
        mismatches = 0;
        comparisons = 0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(bpc_pkg::OFS_DIR, 32'h0000_00ff, bpc_pkg::RESP_OKAY);
        rd(bpc_pkg::OFS_ALT, 32'h0000_0000, bpc_pkg::RESP_OKAY);
        pins(8'h00, 8'h00);
        rd(bpc_pkg::OFS_DATA, 32'h0000_00ff, bpc_pkg::RESP_OKAY);
        // Outputs on all but pins 3:2, inputs held low outside
        wr(bpc_pkg::OFS_DIR, 32'h0000_000c, 4'hf, bpc_pkg::RESP_OKAY);
        wr(bpc_pkg::OFS_DATA, 32'h0000_00a5, 4'hf, bpc_pkg::RESP_OKAY);
        pins(8'ha5, 8'hf3);
        ext_en <= 8'hff;
        repeat (6) @(posedge clk);
        rd(bpc_pkg::OFS_DATA, 32'h0000_00a1, bpc_pkg::RESP_OKAY);
        // Set and clear build on settled pin levels, so let each change settle
        wr(bpc_pkg::OFS_SET, 32'h0000_0002, 4'hf, bpc_pkg::RESP_OKAY);
        pins(8'ha3, 8'hf3);
        repeat (6) @(posedge clk);
        wr(bpc_pkg::OFS_CLR, 32'h0000_0080, 4'hf, bpc_pkg::RESP_OKAY);
        pins(8'h23, 8'hf3);
        rd(bpc_pkg::OFS_SET, 32'h0000_0023, bpc_pkg::RESP_OKAY);
        ext_val <= 8'h08;
        repeat (6) @(posedge clk);
        wr(bpc_pkg::OFS_DATA, 32'h0000_00ff, 4'h0, bpc_pkg::RESP_OKAY);
        pins(8'h2b, 8'hf3);
        // Analog pins read zero but keep their driver control
        ext_val <= 8'hff;
        repeat (6) @(posedge clk);
        rd(bpc_pkg::OFS_DATA, 32'h0000_002f, bpc_pkg::RESP_OKAY);
        wr(bpc_pkg::OFS_ANALOG, 32'h0000_000c, 4'hf, bpc_pkg::RESP_OKAY);
        rd(bpc_pkg::OFS_ANALOG, 32'h0000_000c, bpc_pkg::RESP_OKAY);
        rd(bpc_pkg::OFS_DATA, 32'h0000_0023, bpc_pkg::RESP_OKAY);
        wr(bpc_pkg::OFS_DIR, 32'h0000_0008, 4'hf, bpc_pkg::RESP_OKAY);
        pins(8'h2b, 8'hf7);
        wr(bpc_pkg::OFS_DIR, 32'h0000_000c, 4'hf, bpc_pkg::RESP_OKAY);
        // Alternate location select
        wr(bpc_pkg::OFS_ALT, 32'hffff_ffff, 4'hf, bpc_pkg::RESP_OKAY);
        rd(bpc_pkg::OFS_ALT, 32'h0000_0003, bpc_pkg::RESP_OKAY);
        chk({30'h0, cc2_sel, ss_sel}, 32'h3, "location selects");
        wr(bpc_pkg::OFS_ALT, 32'h0000_0001, 4'hf, bpc_pkg::RESP_OKAY);
        @(negedge clk);
        chk({30'h0, cc2_sel, ss_sel}, 32'h2, "location selects");
        // Unmapped place
        wr(8'h18, 32'h0000_0000, 4'hf, bpc_pkg::RESP_SLVERR);
        rd(8'h18, 32'h0000_0000, bpc_pkg::RESP_SLVERR);
        rd(bpc_pkg::OFS_DIR, 32'h0000_000c, bpc_pkg::RESP_OKAY);
        // Every pin an output
        wr(bpc_pkg::OFS_ANALOG, 32'h0000_0000, 4'hf, bpc_pkg::RESP_OKAY);
        wr(bpc_pkg::OFS_DIR, 32'h0000_0000, 4'hf, bpc_pkg::RESP_OKAY);
        wr(bpc_pkg::OFS_DATA, 32'h0000_005a, 4'hf, bpc_pkg::RESP_OKAY);
        pins(8'h5a, 8'hff);
        repeat (6) @(posedge clk);
        rd(bpc_pkg::OFS_DATA, 32'h0000_005a, bpc_pkg::RESP_OKAY);
        // Second reset in mid-run
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        pins(8'h00, 8'h00);
        rd(bpc_pkg::OFS_DIR, 32'h0000_00ff, bpc_pkg::RESP_OKAY);
        // Clock enable low freezes the pin sampler
        repeat (6) @(posedge clk);
        ce <= 1'b0;
        ext_val <= 8'h3c;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        rd(bpc_pkg::OFS_DATA, 32'h0000_00ff, bpc_pkg::RESP_OKAY);
        repeat (6) @(posedge clk);
        rd(bpc_pkg::OFS_DATA, 32'h0000_003c, bpc_pkg::RESP_OKAY);
        end_sim();
    end
endmodule

`default_nettype wire
